// ==== card_host_port.sv ====
// Behaviour
// - Even byte sits on the low lane from D00, odd byte on the high lane from D08.
// - Task file accesses other than the data register are byte wide on D00-D07 in direct ATA mode.
// - Data register transfers requested word wide are full 16-bit words on D00-D15 in direct ATA mode.
// - In I/O mode the host enables its input data buffers from the input acknowledge.
// - The host grounds the ATA select input to enter direct ATA mode.
// - Only A2-A0 pick among the eight task file registers; upper lines are grounded.
`timescale 1ns/1ps
`default_nettype none
module card_host_port
   import card_port_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Configuration
   input wire logic [1:0] modeSel,
   input wire logic wantMaster,
   // User request
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqCtrlBlock,
   input wire logic [2:0] reqRegIdx,
   input wire logic reqWrite,
   input wire logic reqWordWide,
   input wire logic [15:0] reqWrData,
   // User answer
   output logic rspValid,
   output logic [15:0] rspData,
   output logic dmaPending,
   // Card pins
   output logic cs0N,
   output logic cs1N,
   output logic [10:0] addr,
   output logic iordN,
   output logic iowrN,
   output logic ataSelN,
   output logic roleOut,
   output logic roleOe,
   output logic [15:0] dOut,
   output logic [15:0] dOe,
   input wire logic [15:0] dIn,
   input wire logic inpAckN,
   input wire logic dmaReq,
   // Host side input buffer enable
   output logic rdBufEn
);
   `include "card_port_regs.svh"

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_STROBE,
      ST_RECOVER
   } phase_t;

   typedef struct packed {
      phase_t phase;
      logic [2:0] cnt;
      hostReq_t req;
      logic [15:0] rdData;
      logic rspValid;
      logic roleGnd;
      logic dmaSeen;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   cardMode_t mode;
   logic [15:0] laneData;
   logic [15:0] laneOe;
   logic inStrobe;

   assign mode = cardMode_t'(modeSel);
   assign inStrobe = (st_r.phase == ST_STROBE);

   // Width and lane placement for the request in flight
   lane_pack lane_pack_i (
      .wordWide(st_r.req.wordWide),
      .wrData(st_r.req.wrData),
      .busData(laneData),
      .busOe(laneOe)
   );

   // In direct ATA mode only a data register access is word wide; other modes keep the requested width
   function automatic logic isWord(input logic ctrl, input logic [2:0] idx, input logic ww);
      isWord = ww && !ctrl && (idx == `TF_DATA);
   endfunction

   // ---------------------------------------------------------------
   // Access sequencer
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rspValid = 1'b0;
      st_nxt.dmaSeen = dmaReq && (mode == MODE_DIRECT_ATA);
      // Strap follows the wanted role; no effect outside direct ATA mode
      st_nxt.roleGnd = (mode == MODE_DIRECT_ATA) && wantMaster;
      case (st_r.phase)
         ST_IDLE: begin
            if (reqValid) begin
               st_nxt.req.ctrlBlock = reqCtrlBlock;
               st_nxt.req.regIdx = reqRegIdx;
               st_nxt.req.write = reqWrite;
               st_nxt.req.wordWide = (mode == MODE_DIRECT_ATA) ?
                  isWord(reqCtrlBlock, reqRegIdx, reqWordWide) : reqWordWide;
               st_nxt.req.wrData = reqWrData;
               st_nxt.cnt = 3'(`STROBE_CYC - 1);
               st_nxt.phase = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (st_r.cnt == 3'h0) begin
               // Sample read data at the strobe's end, low lane only for bytes
               if (!st_r.req.write) begin
                  st_nxt.rdData = st_r.req.wordWide ? dIn : {8'h00, dIn[7:0]};
                  st_nxt.rspValid = 1'b1;
               end else begin
                  st_nxt.rspValid = 1'b1;
               end
               st_nxt.cnt = 3'(`RECOVER_CYC - 1);
               st_nxt.phase = ST_RECOVER;
            end else begin
               st_nxt.cnt = st_r.cnt - 3'h1;
            end
         end
         ST_RECOVER: begin
            if (st_r.cnt == 3'h0) begin
               st_nxt.phase = ST_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - 3'h1;
            end
         end
         default: begin
            st_nxt.phase = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   // Selects held for the whole access; they fall with the strobe and stay low through recovery
   assign cs0N = !(st_r.phase != ST_IDLE && !st_r.req.ctrlBlock);
   assign cs1N = !(st_r.phase != ST_IDLE && st_r.req.ctrlBlock);
   assign addr = {8'h00, st_r.req.regIdx};
   assign iordN = !(inStrobe && !st_r.req.write);
   assign iowrN = !(inStrobe && st_r.req.write);
   assign ataSelN = (mode != MODE_DIRECT_ATA);
   // Open drain strap: driven low for master in direct ATA mode, released otherwise
   assign roleOut = 1'b0;
   assign roleOe = st_r.roleGnd;
   assign dOut = laneData;
   assign dOe = (st_r.phase != ST_IDLE && st_r.req.write) ? laneOe : 16'h0000;
   // Buffers open only on a genuine I/O read acknowledge
   assign rdBufEn = (mode == MODE_IO) && inStrobe && !st_r.req.write && !inpAckN;
   assign reqReady = (st_r.phase == ST_IDLE);
   assign rspValid = st_r.rspValid;
   assign rspData = st_r.rdData;
   assign dmaPending = st_r.dmaSeen;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Selects: exactly one register set per access, picked by the request
   sel_exclusive_a: assert property (@(posedge clock) disable iff (rst)
      !(!cs0N && !cs1N)) else $error("both chip selects low");
   task_sel_a: assert property (@(posedge clock) disable iff (rst)
      (reqValid && reqReady && !reqCtrlBlock) |=> (!cs0N && cs1N))
      else $error("task file select wrong");
   ctrl_sel_a: assert property (@(posedge clock) disable iff (rst)
      (reqValid && reqReady && reqCtrlBlock) |=> (!cs1N && cs0N))
      else $error("ctrl select wrong");
   ata_select_a: assert property (@(posedge clock) disable iff (rst)
      (modeSel == 2'h2) == !ataSelN) else $error("ata select level wrong");

   // Strap: grounded only for a master in direct ATA mode, released otherwise
   strap_master_a: assert property (@(posedge clock) disable iff (rst)
      (modeSel == 2'h2 && wantMaster) |=> (roleOe && !roleOut))
      else $error("strap not grounded");
   strap_open_a: assert property (@(posedge clock) disable iff (rst)
      (!wantMaster || modeSel != 2'h2) |=> !roleOe)
      else $error("strap not released");

   // Lanes and widths, for writes on the pins and for read data handed back
   byte_lane_a: assert property (@(posedge clock) disable iff (rst)
      (!dOe[15] && dOe[0]) |-> (dOut[15:8] == 8'h00))
      else $error("high lane not idle");
   word_lanes_a: assert property (@(posedge clock) disable iff (rst)
      (modeSel == 2'h2 && reqValid && reqReady && reqWrite && !reqCtrlBlock
       && reqRegIdx == 3'h0 && reqWordWide) |=> (dOe == 16'hFFFF))
      else $error("word not 16 bit");
   upper_addr_a: assert property (@(posedge clock) disable iff (rst)
      addr[10:3] == 8'h00) else $error("upper address not grounded");
   word_read_a: assert property (@(posedge clock) disable iff (rst)
      (inStrobe && st_r.cnt == 3'h0 && !st_r.req.write && st_r.req.wordWide)
      |=> (rspData == $past(dIn))) else $error("word read lanes wrong");
   byte_read_a: assert property (@(posedge clock) disable iff (rst)
      (inStrobe && st_r.cnt == 3'h0 && !st_r.req.write && !st_r.req.wordWide)
      |=> (rspData == {8'h00, $past(dIn[7:0])})) else $error("byte read not low lane");

   // Read strobe and input acknowledge; a strobe spans five clock cycles
   buf_enable_a: assert property (@(posedge clock) disable iff (rst)
      rdBufEn == (modeSel == 2'h1 && !iordN && !inpAckN))
      else $error("buffer enable wrong");
   strobe_len_a: assert property (@(posedge clock) disable iff (rst)
      $fell(iordN) |-> (!iordN) [*5] ##1 iordN) else $error("read strobe length wrong");

   // DMA request is followed only in direct ATA mode
   dma_gate_a: assert property (@(posedge clock) disable iff (rst)
      (modeSel != 2'h2) |=> !dmaPending) else $error("dma outside ata");
   dma_follow_a: assert property (@(posedge clock) disable iff (rst)
      (modeSel == 2'h2) |=> (dmaPending == $past(dmaReq)))
      else $error("dma request not followed");
endmodule
`default_nettype wire

// ==== card_port_regs.svh ====
`ifndef CARD_PORT_REGS_SVH
`define CARD_PORT_REGS_SVH
// Register indices: data register with the primary chip select, alternate status with the control select
`define TF_DATA 3'h0
`define TF_ALT_STATUS 3'h6
// Field positions on the data bus
`define LOW_LANE_LSB 0
`define HIGH_LANE_LSB 8
// Strobe timing, in nanoseconds, and derived cycle counts at 25 MHz
`define CLK_PERIOD_NS 40
`define STROBE_NS 165
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS 80
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== card_port_pkg.sv ====
`default_nettype none
package card_port_pkg;
   typedef enum logic [1:0] {
      MODE_MEMORY,
      MODE_IO,
      MODE_DIRECT_ATA
   } cardMode_t;

   // One host request as seen on the user side
   typedef struct packed {
      logic ctrlBlock;
      logic [2:0] regIdx;
      logic write;
      logic wordWide;
      logic [15:0] wrData;
   } hostReq_t;

   // Pin group driven toward the card
   typedef struct packed {
      logic cs0N;
      logic cs1N;
      logic [2:0] addr;
      logic iordN;
      logic iowrN;
      logic selRoleN;
      logic selRoleOe;
      logic ataSelN;
      logic [15:0] dOut;
      logic [15:0] dOe;
   } cardPins_t;
endpackage
`default_nettype wire

// ==== lane_pack.sv ====
`timescale 1ns/1ps
`default_nettype none
// Places bytes on the data bus lanes and enables the lanes for the width given with a transfer.
module lane_pack
   import card_port_pkg::*;
(
   // Request
   input wire logic wordWide,
   input wire logic [15:0] wrData,
   // Bus lanes
   output logic [15:0] busData,
   output logic [15:0] busOe
);
   `include "card_port_regs.svh"

   // Even byte on the low lane, odd byte on the high lane
   always_comb begin
      busData = wrData;
      if (wordWide) begin
         busOe = 16'hFFFF;
      end else begin
         busOe = 16'h00FF;
         busData[15:`HIGH_LANE_LSB] = 8'h00;
      end
   end
endmodule
`default_nettype wire

// ==== card_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Card device model
// ----
module card_model (
   // Card pins
   input wire logic cs0N,
   input wire logic cs1N,
   input wire logic [10:0] addr,
   input wire logic iordN,
   input wire logic iowrN,
   input wire logic ataSelN,
   input wire logic roleOut,
   input wire logic roleOe,
   input wire logic [15:0] dOut,
   input wire logic [15:0] dOe,
   output logic [15:0] dIn,
   output logic inpAckN,
   output logic dmaReq,
   // Scenario control
   input wire logic ioMode,
   input wire logic dmaWant,
   output logic isMaster
);
   logic [15:0] dataWord = 16'h0000;
   logic [7:0] taskReg [8];
   logic [15:0] lastOut = 16'h0000;
   logic sel;
   logic strap;
   // Released strap reads high through the pull-up
   assign strap = roleOe ? roleOut : 1'b1;
   assign isMaster = ~ataSelN & ~strap;
   assign sel = ~cs0N | ~cs1N;
   assign inpAckN = ~(ioMode & sel & ~iordN);
   assign dmaReq = ~ataSelN & dmaWant;
   // Read data; a released bus shows the inverse of its last value, not a stale copy
   always_comb begin
      if (sel & ~iordN) begin
         if (~cs1N) dIn = 16'hA550;
         else if (addr[2:0] == 3'h0) dIn = dataWord;
         else dIn = {8'hA5, taskReg[addr[2:0]]};
      end else begin
         dIn = ~lastOut;
      end
   end
   // Remember what was last driven
   always @(dIn) begin
      if (sel & ~iordN) lastOut = dIn;
   end
   // Writes land on the trailing edge of the write strobe
   always @(posedge iowrN) begin
      if (~cs0N && addr[2:0] == 3'h0) dataWord <= dOut & dOe;
      else if (~cs0N) taskReg[addr[2:0]] <= dOut[7:0] & dOe[7:0];
   end
endmodule
`default_nettype wire

// ==== tb_card_host_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_card_host_port;
   import card_port_pkg::*;
   logic clock = 0, rst = 1, wantMaster = 0, reqValid = 0, reqCtrlBlock = 0, dmaWant = 0;
   logic reqWrite = 0, reqWordWide = 0, reqReady, rspValid, dmaPending, cs0N, cs1N;
   logic iordN, iowrN, ataSelN, roleOut, roleOe, inpAckN, dmaReq, rdBufEn, isMaster;
   logic [1:0] modeSel = 2'h2;
   logic [2:0] reqRegIdx = 3'h0;
   logic [15:0] reqWrData = 16'h0000, rspData, dOut, dOe, dIn, midOe;
   logic [10:0] addr, midAddr;
   logic midCs0N, midCs1N, midBuf;
   int err_count = 0, num_checks = 0;
   card_host_port card_host_port_i (.clock(clock), .rst(rst), .modeSel(modeSel),
      .wantMaster(wantMaster), .reqValid(reqValid), .reqReady(reqReady),
      .reqCtrlBlock(reqCtrlBlock), .reqRegIdx(reqRegIdx), .reqWrite(reqWrite),
      .reqWordWide(reqWordWide), .reqWrData(reqWrData), .rspValid(rspValid),
      .rspData(rspData), .dmaPending(dmaPending), .cs0N(cs0N), .cs1N(cs1N), .addr(addr),
      .iordN(iordN), .iowrN(iowrN), .ataSelN(ataSelN), .roleOut(roleOut), .roleOe(roleOe),
      .dOut(dOut), .dOe(dOe), .dIn(dIn), .inpAckN(inpAckN), .dmaReq(dmaReq),
      .rdBufEn(rdBufEn));
   card_model card_model_i (.cs0N(cs0N), .cs1N(cs1N), .addr(addr), .iordN(iordN),
      .iowrN(iowrN), .ataSelN(ataSelN), .roleOut(roleOut), .roleOe(roleOe), .dOut(dOut),
      .dOe(dOe), .dIn(dIn), .inpAckN(inpAckN), .dmaReq(dmaReq),
      .ioMode(modeSel == 2'h1), .dmaWant(dmaWant), .isMaster(isMaster));
   // 25 MHz clock
   initial begin
      forever #20 clock = ~clock;
   end
   // ----
   // Shared tasks
   // ----
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One access; pins are sampled mid-strobe, the wait for the answer is bounded
   task automatic access(input logic c, input logic [2:0] i, input logic w, input logic ww,
         input logic [15:0] d);
      int n;
      n = 0;
      reqCtrlBlock = c;
      reqRegIdx = i;
      reqWrite = w;
      reqWordWide = ww;
      reqWrData = d;
      reqValid = 1;
      while (reqReady !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1 n++;
      end
      if (reqReady !== 1'b1) begin
         check(1'b0, "request never accepted");
         tally_and_finish();
      end
      @(posedge clock);
      #1 reqValid = 0;
      repeat (2) @(posedge clock);
      #1 {midOe, midAddr, midCs0N, midCs1N, midBuf} = {dOe, addr, cs0N, cs1N, rdBufEn};
      n = 0;
      while (rspValid !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1 n++;
      end
      if (rspValid !== 1'b1) begin
         check(1'b0, "access timed out");
         tally_and_finish();
      end
   endtask
   // ----
   // Scenarios
   // ----
   task automatic test_word;
      access(1'b0, 3'h0, 1'b1, 1'b1, 16'hC3A1);
      check(midOe === 16'hFFFF, "word write lanes");
      check(midCs0N === 1'b0 && midCs1N === 1'b1, "task file select");
      access(1'b0, 3'h0, 1'b0, 1'b1, 16'h0000);
      check(rspData === 16'hC3A1, "word read back");
      $display("test word done");
   endtask
   task automatic test_byte;
      access(1'b0, 3'h3, 1'b1, 1'b0, 16'h7E3C);
      check(midOe === 16'h00FF, "byte write lanes");
      check(midAddr === 11'h003, "upper address grounded");
      access(1'b0, 3'h3, 1'b0, 1'b0, 16'h0000);
      check(rspData === 16'h003C, "byte read zero extended");
      access(1'b1, 3'h6, 1'b0, 1'b0, 16'h0000);
      check(midCs1N === 1'b0 && midCs0N === 1'b1, "control select");
      check(rspData === 16'h0050, "status read");
      $display("test byte done");
   endtask
   task automatic test_role_ack_dma;
      for (int m = 0; m < 3; m++) begin
         for (int w = 0; w < 2; w++) begin
            modeSel = m[1:0];
            wantMaster = w[0];
            repeat (3) @(posedge clock);
            #1 check(isMaster === (m == 2 && w == 1), "role strap");
            check(roleOe === (m == 2 && w == 1), "strap drive");
         end
      end
      modeSel = 2'h1;
      access(1'b0, 3'h0, 1'b0, 1'b0, 16'h0000);
      check(midBuf === 1'b1 && inpAckN === 1'b1, "io read buffer");
      check(rspData === 16'h00A1, "io byte read low lane");
      modeSel = 2'h0;
      access(1'b0, 3'h0, 1'b0, 1'b0, 16'h0000);
      check(midBuf === 1'b0, "memory mode buffer");
      modeSel = 2'h2;
      dmaWant = 1;
      repeat (3) @(posedge clock);
      #1 check(dmaPending === 1'b1, "dma request");
      dmaWant = 0;
      repeat (3) @(posedge clock);
      #1 check(dmaPending === 1'b0, "dma idle");
      $display("test role ack dma done");
   endtask
   // Reset lands in the strobe's first cycle; pins fall back to idle, the strap returns after release
   task automatic test_reset;
      reqCtrlBlock = 1'b0;
      reqRegIdx = 3'h1;
      reqWrite = 1'b0;
      reqWordWide = 1'b0;
      reqValid = 1'b1;
      @(posedge clock);
      #1 reqValid = 1'b0;
      rst = 1'b1;
      check(cs0N === 1'b0 && iordN === 1'b0, "access before reset");
      repeat (2) @(posedge clock);
      #1 check(cs0N === 1'b1 && cs1N === 1'b1, "reset idles selects");
      check(iordN === 1'b1 && dOe === 16'h0000, "reset idles strobe");
      check(reqReady === 1'b1 && roleOe === 1'b0, "reset releases strap");
      rst = 1'b0;
      repeat (2) @(posedge clock);
      #1 check(roleOe === 1'b1 && isMaster === 1'b1, "strap after reset");
      $display("test reset done");
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clock);
      #1 rst = 0;
      test_word();
      test_byte();
      test_role_ack_dma();
      test_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
